// >>> asop_params.svh
// asop_params.svh: register offsets, field positions, reset values and fifo levels
// assumes inclusion by asop_core; definitions only
`ifndef ASOP_PARAMS_SVH
`define ASOP_PARAMS_SVH
`define ASOP_OFS_CTRL 8'h00
`define ASOP_OFS_MASK 8'h04
`define ASOP_OFS_RAW 8'h08
`define ASOP_OFS_MSK 8'h0c
`define ASOP_OFS_CLR 8'h10
`define ASOP_OFS_DATA 8'h14
`define ASOP_CTRL_RST 7'h0c
`define ASOP_MASK_RST 8'h00
`define ASOP_B_DMA 6
`define ASOP_B_LB 5
`define ASOP_B_INV 4
`define ASOP_B_STEREO 3
`define ASOP_B_W18 2
`define ASOP_B_RDERR 6
`define ASOP_B_FULL 1
`define ASOP_B_WRERR 0
`define ASOP_DEPTH 8'h80
`define ASOP_HALF 8'h40
`define ASOP_AE_DEF 8'h10
`define ASOP_AF_DEF 8'h70
`define ASOP_LAST128 9'h07f
`define ASOP_LAST256 9'h0ff
`define ASOP_LAST512 9'h1ff
`endif

// >>> asop_pkg.sv
// asop_pkg.sv: state types of the serial output port
// assumes asop_params.svh sits beside it
package asop_pkg;
  typedef struct packed {
    logic [6:0] ctrl;
    logic [7:0] mask;
    logic rd_err;
    logic wr_err;
    logic next_ch;
    logic [17:0] left_hold;
    logic [7:0] wgray;
    logic [7:0] rg_s1;
    logic [7:0] rg_s2;
    logic [2:0] rerr_s;
    logic [31:0] prdata;
    logic irq;
  } asop_bus_t;
  typedef struct packed {
    logic [8:0] cnt;
    logic [7:0] rgray;
    logic [7:0] wg_s1;
    logic [7:0] wg_s2;
    logic [3:0] cfg_s1;
    logic [3:0] cfg_s2;
    logic [35:0] frame;
    logic sclk;
    logic lrck;
    logic sdata;
    logic rerr_tog;
    logic [2:0] lb_s;
    logic lb_val;
  } asop_aud_t;
endpackage

// >>> asop_core.sv
// asop_core.sv: serial audio output port, register slave, dual-clock fifo, serialiser
// assumes a peripheral-bus master on clk_i and a master audio clock that may stop
`timescale 1ns/1ps
`default_nettype none
`include "asop_params.svh"
module asop_core
  import asop_pkg::*;
#(
  parameter logic [7:0] AE_LVL = `ASOP_AE_DEF,
  parameter logic [7:0] AF_LVL = `ASOP_AF_DEF
) (
  // bus clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // peripheral bus slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  // system requests
  output logic dma_req_o,
  output logic irq_o,
  // audio side
  input wire logic audio_master_clock_i,
  input wire logic input_loopback_data_i,
  output logic serial_bit_clock_o,
  output logic frame_channel_clock_o,
  output logic serial_data_out_o
);

  if (AE_LVL >= `ASOP_HALF || AF_LVL <= `ASOP_HALF || AF_LVL > `ASOP_DEPTH) begin : g_chk
    $error("asop_core: fifo levels out of order");
  end

  localparam asop_bus_t B_RST = '{ctrl: `ASOP_CTRL_RST, mask: `ASOP_MASK_RST, default: '0};

  function automatic logic [7:0] bin2gray(input logic [7:0] v);
    return v ^ (v >> 1);
  endfunction

  function automatic logic [7:0] gray2bin(input logic [7:0] g);
    logic [7:0] r;
    r = g;
    for (int i = 6; i >= 0; i--) begin
      r[i] = r[i+1] ^ g[i];
    end
    return r;
  endfunction

  asop_bus_t b_reg;
  asop_bus_t b_next;
  asop_aud_t a_reg;
  asop_aud_t a_next;
  logic [35:0] mem [0:127];

  logic wr_acc;
  logic rd_setup;
  logic data_wr;
  logic clr_wr;
  logic st;
  logic w18;
  logic push;
  logic wr_pulse;
  logic rd_pulse;
  logic [7:0] wbin;
  logic [7:0] wlevel;
  logic [7:0] raw;
  logic [7:0] masked;
  logic [35:0] wentry;

  // bus domain
  always_comb begin
    b_next = b_reg;
    wr_acc = psel_i && penable_i && pwrite_i;
    rd_setup = psel_i && !penable_i && !pwrite_i;
    data_wr = wr_acc && paddr_i == `ASOP_OFS_DATA;
    clr_wr = wr_acc && paddr_i == `ASOP_OFS_CLR;
    st = b_reg.ctrl[`ASOP_B_STEREO];
    w18 = b_reg.ctrl[`ASOP_B_W18];
    wbin = gray2bin(b_reg.wgray);
    wlevel = wbin - gray2bin(b_reg.rg_s2);
    raw[7] = b_reg.next_ch;
    raw[6] = b_reg.rd_err;
    raw[5] = wlevel == 8'h00;
    raw[4] = wlevel <= AE_LVL;
    raw[3] = wlevel >= `ASOP_HALF;
    raw[2] = wlevel >= AF_LVL;
    raw[1] = wlevel == `ASOP_DEPTH;
    raw[0] = b_reg.wr_err;
    // status bit 7 is informational only
    masked = raw & {1'b0, b_reg.mask[6:0]};
    // 16-bit samples go msb-aligned into 18-bit slots
    if (!st) begin
      wentry = w18 ? {2{pwdata_i[17:0]}} : {2{pwdata_i[15:0], 2'b00}};
      push = data_wr;
    end else if (!w18) begin
      wentry = {pwdata_i[31:16], 2'b00, pwdata_i[15:0], 2'b00};
      push = data_wr;
    end else begin
      wentry = {b_reg.left_hold, pwdata_i[17:0]};
      push = data_wr && b_reg.next_ch;
    end
    wr_pulse = push && raw[`ASOP_B_FULL];
    if (data_wr && st && w18) begin
      b_next.next_ch = !b_reg.next_ch;
      if (!b_reg.next_ch) begin
        b_next.left_hold = pwdata_i[17:0];
      end
    end
    if (push && !raw[`ASOP_B_FULL]) begin
      b_next.wgray = bin2gray(wbin + 8'h01);
    end
    b_next.rg_s1 = a_reg.rgray;
    b_next.rg_s2 = b_reg.rg_s1;
    b_next.rerr_s = {b_reg.rerr_s[1:0], a_reg.rerr_tog};
    rd_pulse = b_reg.rerr_s[1] ^ b_reg.rerr_s[2];
    // a pulse in the clearing cycle wins over the clear
    if (clr_wr && pwdata_i[`ASOP_B_RDERR]) begin
      b_next.rd_err = 1'b0;
    end
    if (rd_pulse) begin
      b_next.rd_err = 1'b1;
    end
    if (clr_wr && pwdata_i[`ASOP_B_WRERR]) begin
      b_next.wr_err = 1'b0;
    end
    if (wr_pulse) begin
      b_next.wr_err = 1'b1;
    end
    if (wr_acc && paddr_i == `ASOP_OFS_CTRL) begin
      b_next.ctrl = pwdata_i[6:0];
    end
    if (wr_acc && paddr_i == `ASOP_OFS_MASK) begin
      b_next.mask = pwdata_i[7:0];
    end
    if (rd_setup) begin
      case (paddr_i)
        `ASOP_OFS_CTRL: b_next.prdata = {25'h0, b_reg.ctrl};
        `ASOP_OFS_MASK: b_next.prdata = {24'h0, b_reg.mask};
        `ASOP_OFS_RAW: b_next.prdata = {24'h0, raw};
        `ASOP_OFS_MSK: b_next.prdata = {24'h0, masked};
        default: b_next.prdata = 32'h0;
      endcase
    end
    b_next.irq = |masked;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b_reg <= B_RST;
    end else begin
      b_reg <= b_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push && !raw[`ASOP_B_FULL]) begin
      mem[wbin[6:0]] <= wentry;
    end
  end

  assign prdata_o = b_reg.prdata;
  assign irq_o = b_reg.irq;
  assign dma_req_o = b_reg.ctrl[`ASOP_B_DMA] && !raw[`ASOP_B_FULL];

  // audio master clock domain
  logic [1:0] arst_s;
  logic a_rst;
  logic [1:0] sh;
  logic [8:0] last;
  logic [8:0] sft;
  logic [5:0] bidx;
  logic [4:0] slot;
  logic [5:0] idx;
  logic [7:0] rbin;
  logic fbit;
  logic msb_now;
  logic [2:0] neg_reg;

  always_ff @(posedge audio_master_clock_i) begin
    arst_s <= {arst_s[0], rst_i};
  end
  assign a_rst = arst_s[1];

  always_comb begin
    a_next = a_reg;
    a_next.cfg_s1 = {b_reg.ctrl[`ASOP_B_LB], b_reg.ctrl[`ASOP_B_INV], b_reg.ctrl[1:0]};
    a_next.cfg_s2 = a_reg.cfg_s1;
    a_next.wg_s1 = b_reg.wgray;
    a_next.wg_s2 = a_reg.wg_s1;
    a_next.lb_s = {a_reg.lb_s[1:0], input_loopback_data_i};
    if (a_reg.lb_s[1] == a_reg.lb_s[2]) begin
      a_next.lb_val = a_reg.lb_s[2];
    end
    case (a_reg.cfg_s2[1:0])
      2'b01: begin
        sh = 2'd2;
        last = `ASOP_LAST256;
      end
      2'b10: begin
        sh = 2'd3;
        last = `ASOP_LAST512;
      end
      default: begin
        sh = 2'd1;
        last = `ASOP_LAST128;
      end
    endcase
    sft = a_reg.cnt >> sh;
    bidx = sft[5:0];
    slot = bidx[4:0];
    rbin = gray2bin(a_reg.rgray);
    // frames are fetched only on master clock edges, so a stopped clock reads nothing
    if (a_reg.cnt == last) begin
      a_next.cnt = 9'h000;
      if (a_reg.rgray == a_reg.wg_s2) begin
        a_next.frame = 36'h0;
        a_next.rerr_tog = !a_reg.rerr_tog;
      end else begin
        a_next.frame = mem[rbin[6:0]];
        a_next.rgray = bin2gray(rbin + 8'h01);
      end
    end else begin
      a_next.cnt = a_reg.cnt + 9'h001;
    end
    idx = (bidx[5] ? 6'd18 : 6'd36) - {1'b0, slot};
    fbit = 1'b0;
    if (slot != 5'd0 && slot <= 5'd18) begin
      fbit = a_reg.frame[idx];
    end
    msb_now = bidx[5] ? a_reg.frame[17] : a_reg.frame[35];
    a_next.sclk = a_reg.cnt[sh - 2'd1];
    a_next.lrck = bidx[5];
    // loopback is retimed only, so it must already share this bit clock
    a_next.sdata = a_reg.cfg_s2[3] ? a_reg.lb_val : fbit;
  end

  always_ff @(posedge audio_master_clock_i) begin
    if (a_rst) begin
      a_reg <= '0;
    end else begin
      a_reg <= a_next;
    end
  end

  // half-cycle retime so the clocks can change on the falling master edge
  always_ff @(negedge audio_master_clock_i) begin
    if (a_rst) begin
      neg_reg <= 3'h0;
    end else begin
      neg_reg <= {a_reg.sclk, a_reg.lrck, a_reg.sdata};
    end
  end

  assign serial_bit_clock_o = a_reg.cfg_s2[2] ? a_reg.sclk : neg_reg[2];
  assign frame_channel_clock_o = a_reg.cfg_s2[2] ? a_reg.lrck : neg_reg[1];
  assign serial_data_out_o = a_reg.cfg_s2[2] ? a_reg.sdata : neg_reg[0];

  a_wr_err_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    b_reg.wr_err && !(clr_wr && pwdata_i[0]) |=> b_reg.wr_err)
    else $error("write error flag dropped without clear");

  a_rd_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_wr && pwdata_i[6] && !rd_pulse |=> !b_reg.rd_err)
    else $error("read error flag not cleared");

  a_wr_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_wr && pwdata_i[0] && !wr_pulse |=> !b_reg.wr_err)
    else $error("write error flag not cleared");

  a_ctrl_reset_val: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> b_reg.ctrl == `ASOP_CTRL_RST)
    else $error("control reset value wrong");

  a_dma_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !b_reg.ctrl[6] |-> !dma_req_o)
    else $error("dma request while disabled");

  a_masked_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_setup && paddr_i == `ASOP_OFS_MSK |=> prdata_o == {24'h0, $past(masked)} && !prdata_o[7])
    else $error("masked status read wrong");

  a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (|masked) |=> irq_o)
    else $error("interrupt missing for masked flag");

  a_pair_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    data_wr && st && w18 && !b_reg.next_ch |=> b_reg.next_ch && $stable(b_reg.wgray))
    else $error("left sample pushed alone");

  a_mono_dup: assert property (@(posedge clk_i) disable iff (rst_i)
    push && !st |-> wentry[35:18] == wentry[17:0])
    else $error("mono sample not duplicated");

  a_full_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    push && raw[1] |=> $stable(b_reg.wgray) && b_reg.wr_err)
    else $error("push into full fifo");

  a_msb_slot: assert property (@(posedge audio_master_clock_i) disable iff (a_rst)
    slot == 5'd1 && !a_reg.cfg_s2[3] |=> a_reg.sdata == $past(msb_now))
    else $error("msb not one bit after frame edge");

  a_frame_256: assert property (@(posedge audio_master_clock_i) disable iff (a_rst)
    a_reg.cnt == 9'h000 && a_reg.cfg_s2[1:0] == 2'b01 && $stable(a_reg.cfg_s2) |->
    ##256 (a_reg.cnt == 9'h000 || a_reg.cfg_s2[1:0] != 2'b01))
    else $error("256x frame length wrong");

endmodule
`default_nettype wire

// >>> asop_dac_model.sv
// asop_dac_model.sv: behavioural stereo dac that captures serial frames
// assumes bit clock, frame clock and data come from the port under test
`timescale 1ns/1ps
`default_nettype none
module asop_dac_model (
  // serial link
  input wire logic sclk_i,
  input wire logic lrck_i,
  input wire logic sdata_i,
  // captured frame, left in [35:18], strobe for one bit clock
  output logic [35:0] frame_o,
  output logic stb_o
);
  logic lr_q;
  logic [5:0] cnt;
  logic [17:0] lsh;
  logic [17:0] rsh;
  initial begin
    lr_q = 1'b0;
    cnt = 6'h12;
    lsh = '0;
    rsh = '0;
    frame_o = '0;
    stb_o = 1'b0;
  end
  // slot bit 0 follows the frame edge and is skipped, so msb is slot bit 1
  always @(posedge sclk_i) begin
    stb_o <= 1'b0;
    lr_q <= lrck_i;
    if (lrck_i != lr_q) begin
      cnt <= 6'h00;
    end else if (cnt < 6'h12) begin
      cnt <= cnt + 6'h01;
      if (!lrck_i) begin
        lsh <= {lsh[16:0], sdata_i};
      end else begin
        rsh <= {rsh[16:0], sdata_i};
      end
      if (lrck_i && cnt == 6'h11) begin
        frame_o <= {lsh, rsh[16:0], sdata_i};
        stb_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> asop_tb_top.sv
// asop_tb_top.sv: self-checking bench for the serial audio output port
// assumes asop_core and asop_dac_model; frames are checked through a queue
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module asop_tb_top;
  import asop_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rv, d, e;
  logic dma_req_o, irq_o, mclk = 1'b0, mclk_en = 1'b1, lb_i = 1'b0, lb_mode = 1'b0;
  logic sclk, lrck, sdata, stb;
  logic [35:0] frame, x;
  logic [2:0] held;
  logic [31:0] seed = 32'd96288;
  logic [35:0] q[$];
  int err_count = 0, total_checks = 0;
  logic [7:0] modes [4] = '{8'h08, 8'h0c, 8'h00, 8'h04};
  asop_core i_asop_core (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .dma_req_o(dma_req_o), .irq_o(irq_o), .audio_master_clock_i(mclk), .input_loopback_data_i(lb_i),
    .serial_bit_clock_o(sclk), .frame_channel_clock_o(lrck), .serial_data_out_o(sdata));
  asop_dac_model i_asop_dac_model (.sclk_i(sclk), .lrck_i(lrck), .sdata_i(sdata), .frame_o(frame),
    .stb_o(stb));
  always #10 clk_i = ~clk_i;
  always begin
    #62.5;
    if (mclk_en) mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed | 32'h00010001;
  endfunction
  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk_i) {psel_i, pwrite_i, paddr_i, pwdata_i} = {2'b11, a, v};
    @(negedge clk_i) penable_i = 1'b1;
    @(negedge clk_i) {psel_i, penable_i} = 2'b00;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk_i) {psel_i, pwrite_i, paddr_i} = {2'b10, a};
    @(negedge clk_i) penable_i = 1'b1;
    @(negedge clk_i) v = prdata_o;
    {psel_i, penable_i} = 2'b00;
  endtask
  task cr(input logic [7:0] a, input logic [31:0] ex);
    rd(a, rv);
    `CHK(rv, ex)
  endtask
  task wait_q();
    for (int k = 0; k < 40000 && q.size() != 0; k++) @(negedge clk_i);
    if (q.size() != 0) begin
      err_count++;
      end_sim();
    end
    // a whole 512x frame must pass so the serialiser holds a zero frame before the next mode change
    repeat (3300) @(negedge clk_i);
  endtask
  // an empty fifo sends zero frames; random samples always carry a set bit, so a zero
  // frame seen while notes are pending is underflow still in flight, not queued data
  always @(posedge stb) begin
    if (q.size() != 0 && frame !== 36'h0) begin
      x = q.pop_front();
      `CHK(frame, x)
    end else if (!lb_mode && q.size() == 0) begin
      `CHK(frame, 36'h0)
    end
  end
  initial begin
    // reset spans three master clock edges as well, for the synchroniser
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    cr(8'h00, 32'h0000000c);
    cr(8'h04, 32'h0);
    cr(8'h08, 32'h00000030);
    cr(8'h18, 32'h0);
    `CHK({dma_req_o, irq_o}, 2'b00)
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {24'h0, modes[i] | (i[0] ? 8'h10 : 8'h00) | 8'(i)});
      repeat (200) @(negedge clk_i);
      for (int s = 0; s < 3; s++) begin
        d = rnd();
        e = rnd();
        case (i)
          0: q.push_back({d[31:16], 2'b00, d[15:0], 2'b00});
          1: q.push_back({d[17:0], e[17:0]});
          2: q.push_back({d[15:0], 2'b00, d[15:0], 2'b00});
          default: q.push_back({d[17:0], d[17:0]});
        endcase
        wr(8'h14, d);
        if (i == 1) begin
          rd(8'h08, rv);
          `CHK(rv[7], 1'b1)
          wr(8'h14, e);
        end
      end
      wait_q();
      $display("mode test %0d done", i);
    end
    // loopback data held high, which any bit clock samples as ones
    lb_mode = 1'b1;
    lb_i = 1'b1;
    wr(8'h00, 32'h0000002c);
    repeat (3000) @(negedge clk_i);
    `CHK(frame, 36'hfffffffff)
    wr(8'h00, 32'h0000000c);
    repeat (2000) @(negedge clk_i);
    lb_mode = 1'b0;
    $display("loopback test done");
    mclk_en = 1'b0;
    repeat (10) @(negedge clk_i);
    held = {sclk, lrck, sdata};
    cr(8'h08, 32'h00000070);
    repeat (100) @(negedge clk_i);
    `CHK({sclk, lrck, sdata}, held)
    wr(8'h04, 32'h0000007f);
    cr(8'h0c, 32'h00000070);
    `CHK(irq_o, 1'b1)
    wr(8'h10, 32'h00000040);
    cr(8'h08, 32'h00000030);
    wr(8'h04, 32'h00000080);
    // a lone left sample raises the next-channel bit, which mask bit 7 must not pass
    wr(8'h14, rnd());
    cr(8'h0c, 32'h0);
    `CHK(irq_o, 1'b0)
    // the right sample completes the pair; its entry stays queued while the master clock is stopped
    wr(8'h14, rnd());
    $display("status test done");
    wr(8'h00, 32'h00000040);
    `CHK(dma_req_o, 1'b1)
    for (int s = 0; s < 127; s++) wr(8'h14, rnd());
    cr(8'h08, 32'h0000000e);
    `CHK(dma_req_o, 1'b0)
    wr(8'h14, 32'h1);
    wr(8'h08, 32'h0);
    cr(8'h08, 32'h0000000f);
    wr(8'h10, 32'h00000001);
    cr(8'h08, 32'h0000000e);
    wr(8'h00, 32'h000000ff);
    cr(8'h00, 32'h0000007f);
    $display("fill test done");
    end_sim();
  end
endmodule
`default_nettype wire
